// ### rtl/swkcf_top.sv
// selective wake fd tolerance, dominant filter and oscillator trim registers
//
// Notes on behaviour
// - error-counter disable stops the error counter only in fd tolerant mode
// - bus-silence timeout expiry clears error-counter disable in hardware
// - filter codes 0-6 give 50..350 ns in 50 ns steps, code 7 775 ns
// - fd control bit 0 enables fd tolerant mode when 1
// - receiver select bit 14: 0 low-power, 1 standard receiver
// - receiver select is accessible only while trim enable holds 11
// - temperature coefficient trim 11:7 writable only with trim enable 11
// - oscillator coarse trim bits 6:0 writable only with trim enable 11
// - low-power receiver is the default, giving least quiescent current
// - calibration register shows high byte 15:8 and low byte 7:0, read-only
// - reserved bits read zero and ignore writes
//
// The AXI4-Lite slave port is this design's own decision.
`include "swkcf_regs.svh"

module swkcf_top
#(
   parameter int ADDR_W    = 12,
   parameter int ERR_CNT_W = 8
)
(
   input  wire logic                   I_CLK_SYS,
   input  wire logic                   I_RST,
   input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output swkcf_pkg::swkcf_resp_e      S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output swkcf_pkg::swkcf_resp_e      S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   input  wire logic                   I_SWK_ACTIVE,
   input  wire logic                   I_SILENCE_EXPIRED,
   input  wire logic                   I_FRAME_ERR,
   input  wire logic                   I_CAN_RXD,
   input  wire logic [7:0]             I_CAL_HIGH,
   input  wire logic [7:0]             I_CAL_LOW,
   output logic                        O_FD_TOLERANT_EN,
   output logic                        O_ERR_CNT_RUN,
   output logic [ERR_CNT_W-1:0]        O_ERR_CNT,
   output logic                        O_WAKE_RX_STD,
   output logic [4:0]                  O_TEMP_COEF_TRIM,
   output logic [6:0]                  O_OSC_COARSE_TRIM,
   output logic                        O_RXD_FILT
);
   import swkcf_pkg::*;

   // index of a byte address, as used by both address channels
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction

   // is the address one of ours (word aligned, no upper bits)
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      addr_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
                 (i == `SWKCF_IDX_FD || i == `SWKCF_IDX_TRIM ||
                  i == `SWKCF_IDX_CAL || i == `SWKCF_IDX_UNLOCK ||
                  i == `SWKCF_IDX_ERRCNT);
   endfunction

   // byte-lane merge of a write into a 16-bit register
   function automatic swkcf_reg_t merge(input swkcf_reg_t old,
                                        input logic [31:0] d,
                                        input logic [3:0] s,
                                        input swkcf_reg_t wmask);
      swkcf_reg_t m;
      m = {{8{s[1]}}, {8{s[0]}}} & wmask;
      merge = (old & ~m) | (d[15:0] & m);
   endfunction

   // filter time in cycles, least time rounded up
   function automatic logic [7:0] filt_cycles(input logic [2:0] code);
      int ns;
      ns = (code == 3'h7) ? `SWKCF_FILT_LONG_NS
                          : (int'(code) + 1) * `SWKCF_FILT_STEP_NS;
      filt_cycles = 8'((ns * 1000 + `SWKCF_CLK_PS - 1) / `SWKCF_CLK_PS);
   endfunction

   // ---------------- bus state ----------------
   logic              aw_full_r, aw_full_nxt;
   logic              w_full_r, w_full_nxt;
   logic [7:0]        aw_idx_r, aw_idx_nxt;
   logic              aw_hit_r, aw_hit_nxt;
   logic [31:0]       wdata_r, wdata_nxt;
   logic [3:0]        wstrb_r, wstrb_nxt;
   logic              bvalid_r, bvalid_nxt;
   swkcf_resp_e       bresp_r, bresp_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   swkcf_resp_e       rresp_r, rresp_nxt;
   logic              do_write;

   // ---------------- register state ----------------
   swkcf_reg_t        fd_r, fd_nxt;
   swkcf_reg_t        trim_r, trim_nxt;
   swkcf_reg_t        cal_r, cal_nxt;
   logic [1:0]        unlock_r, unlock_nxt;
   logic [ERR_CNT_W-1:0] errcnt_r, errcnt_nxt;
   logic              unlocked;
   logic              cnt_stop;

   // ---------------- filter state ----------------
   swkcf_filt_e       filt_st_r, filt_st_nxt;
   logic [7:0]        dom_cnt_r, dom_cnt_nxt;

   assign unlocked = (unlock_r == `SWKCF_TRIM_KEY);
   // counter only stops in fd tolerant mode
   assign cnt_stop = fd_r[`SWKCF_FD_EN_BIT] & fd_r[`SWKCF_ECD_BIT];
   assign do_write = aw_full_r & w_full_r & ~bvalid_r;

   // write channels: address and data taken in either order, then answer
   always_comb
   begin
      aw_full_nxt = aw_full_r;
      aw_idx_nxt  = aw_idx_r;
      aw_hit_nxt  = aw_hit_r;
      w_full_nxt  = w_full_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         aw_full_nxt = 1'b1;
         aw_idx_nxt  = reg_index(S_AXI_AWADDR);
         aw_hit_nxt  = addr_hit(S_AXI_AWADDR);
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         w_full_nxt = 1'b1;
         wdata_nxt  = S_AXI_WDATA;
         wstrb_nxt  = S_AXI_WSTRB;
      end
      if (do_write)
      begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         // locked trim writes still answer okay
         bresp_nxt   = aw_hit_r ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid_r && S_AXI_BREADY)
      begin
         bvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         aw_full_r <= 1'b0;
         aw_idx_r  <= 8'h00;
         aw_hit_r  <= 1'b0;
         w_full_r  <= 1'b0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= AXI_OKAY;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         aw_idx_r  <= aw_idx_nxt;
         aw_hit_r  <= aw_hit_nxt;
         w_full_r  <= w_full_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
      end
   end

   // one write in flight: hold off new beats until the answer is taken
   assign S_AXI_AWREADY = ~aw_full_r & ~bvalid_r;
   assign S_AXI_WREADY  = ~w_full_r & ~bvalid_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;

   // read channel: answer one cycle after the address is taken
   always_comb
   begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = addr_hit(S_AXI_ARADDR) ? AXI_OKAY : AXI_SLVERR;
         rdata_nxt  = 32'h0000_0000;
         if (addr_hit(S_AXI_ARADDR))
         begin
            case (reg_index(S_AXI_ARADDR))
               `SWKCF_IDX_FD:
                  rdata_nxt[15:0] = fd_r & `SWKCF_FD_WMASK;
               `SWKCF_IDX_TRIM:
               begin
                  rdata_nxt[15:0] = trim_r & `SWKCF_TRIM_WMASK;
                  // receiver select hidden while locked
                  if (!unlocked)
                  begin
                     rdata_nxt[`SWKCF_RXSEL_BIT] = 1'b0;
                  end
               end
               `SWKCF_IDX_CAL:
                  rdata_nxt[15:0] = cal_r;
               `SWKCF_IDX_UNLOCK:
                  rdata_nxt[1:0] = unlock_r;
               `SWKCF_IDX_ERRCNT:
                  rdata_nxt[ERR_CNT_W-1:0] = errcnt_r;
               default:
                  rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
      else if (rvalid_r && S_AXI_RREADY)
      begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= AXI_OKAY;
      end
      else
      begin
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
         rresp_r  <= rresp_nxt;
      end
   end

   assign S_AXI_ARREADY = ~rvalid_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;

   // registers, hardware clear and error counter
   always_comb
   begin
      fd_nxt     = fd_r;
      trim_nxt   = trim_r;
      unlock_nxt = unlock_r;
      errcnt_nxt = errcnt_r;
      cal_nxt    = {I_CAL_HIGH, I_CAL_LOW};
      if (do_write && aw_hit_r)
      begin
         case (aw_idx_r)
            `SWKCF_IDX_FD:
               fd_nxt = merge(fd_r, wdata_r, wstrb_r, `SWKCF_FD_WMASK);
            `SWKCF_IDX_TRIM:
               // locked: silently keep the stored trim values
               if (unlocked)
               begin
                  trim_nxt = merge(trim_r, wdata_r, wstrb_r,
                                   `SWKCF_TRIM_WMASK);
               end
            `SWKCF_IDX_UNLOCK:
               if (wstrb_r[0])
               begin
                  unlock_nxt = wdata_r[`SWKCF_KEY_MSB:0];
               end
            default:
               fd_nxt = fd_r;
         endcase
      end
      // expiry wins over a software set in the same cycle
      if (I_SILENCE_EXPIRED)
      begin
         fd_nxt[`SWKCF_ECD_BIT] = 1'b0;
      end
      // counts frame errors during wake, saturating, unless stopped
      if (!I_SWK_ACTIVE)
      begin
         errcnt_nxt = '0;
      end
      else if (I_FRAME_ERR && !cnt_stop && !(&errcnt_r))
      begin
         errcnt_nxt = errcnt_r + 1'b1;
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         fd_r     <= `SWKCF_FD_RST;
         trim_r   <= `SWKCF_TRIM_RST;
         cal_r    <= `SWKCF_CAL_RST;
         unlock_r <= `SWKCF_UNLOCK_RST;
         errcnt_r <= '0;
      end
      else
      begin
         fd_r     <= fd_nxt;
         trim_r   <= trim_nxt;
         cal_r    <= cal_nxt;
         unlock_r <= unlock_nxt;
         errcnt_r <= errcnt_nxt;
      end
   end

   // dominant glitch filter: low must last the selected time to pass
   always_comb
   begin
      filt_st_nxt = filt_st_r;
      dom_cnt_nxt = dom_cnt_r;
      case (filt_st_r)
         FS_RECESSIVE:
            if (I_CAN_RXD)
            begin
               dom_cnt_nxt = 8'h00;
            end
            else if (dom_cnt_r + 8'h01 >=
                     filt_cycles(fd_r[`SWKCF_FILT_MSB:`SWKCF_FILT_LSB]))
            begin
               filt_st_nxt = FS_DOMINANT;
               dom_cnt_nxt = 8'h00;
            end
            else
            begin
               dom_cnt_nxt = dom_cnt_r + 8'h01;
            end
         FS_DOMINANT:
            if (I_CAN_RXD)
            begin
               filt_st_nxt = FS_RECESSIVE;
            end
         default:
            filt_st_nxt = FS_RECESSIVE;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         filt_st_r <= FS_RECESSIVE;
         dom_cnt_r <= 8'h00;
      end
      else
      begin
         filt_st_r <= filt_st_nxt;
         dom_cnt_r <= dom_cnt_nxt;
      end
   end

   // block outputs, all from flops
   assign O_FD_TOLERANT_EN  = fd_r[`SWKCF_FD_EN_BIT];
   assign O_ERR_CNT_RUN     = ~cnt_stop;
   assign O_ERR_CNT         = errcnt_r;
   assign O_WAKE_RX_STD     = trim_r[`SWKCF_RXSEL_BIT];
   assign O_TEMP_COEF_TRIM  = trim_r[`SWKCF_TC_MSB:`SWKCF_TC_LSB];
   assign O_OSC_COARSE_TRIM = trim_r[`SWKCF_OT_MSB:`SWKCF_OT_LSB];
   assign O_RXD_FILT        = (filt_st_r == FS_RECESSIVE);

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   sequence s_wr_trim;
      do_write && aw_hit_r && aw_idx_r == `SWKCF_IDX_TRIM;
   endsequence

   a_err_cnt_stop: assert property (
      I_SWK_ACTIVE && $past(I_SWK_ACTIVE) && $past(cnt_stop)
      |-> $stable(errcnt_r))
      else $error("error counter moved while disabled");
   a_err_cnt_run: assert property (
      I_SWK_ACTIVE && I_FRAME_ERR && !cnt_stop && !(&errcnt_r)
      |=> errcnt_r == $past(errcnt_r) + 1'b1)
      else $error("error counter missed an error");
   a_silence_clear: assert property (
      I_SILENCE_EXPIRED |=> !fd_r[`SWKCF_ECD_BIT])
      else $error("disable bit survived silence expiry");
   a_filter_time: assert property (
      filt_st_r == FS_RECESSIVE && I_CAN_RXD ##1 !I_CAN_RXD[*2]
      |-> O_RXD_FILT)
      else $error("dominant passed before the shortest filter time");
   a_fd_enable: assert property (
      do_write && aw_hit_r && aw_idx_r == `SWKCF_IDX_FD && wstrb_r[0]
      |=> O_FD_TOLERANT_EN == $past(wdata_r[0]))
      else $error("fd tolerant enable not taken");
   a_trim_locked: assert property (
      s_wr_trim and !unlocked |=> $stable(trim_r))
      else $error("locked trim write changed the register");
   a_trim_open: assert property (
      s_wr_trim and unlocked and wstrb_r[0]
      |=> O_OSC_COARSE_TRIM == $past(wdata_r[6:0]))
      else $error("unlocked coarse trim write lost");
   a_rxsel_hidden: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY && !unlocked
      && S_AXI_ARADDR == ADDR_W'({`SWKCF_IDX_TRIM, 2'h0})
      |=> S_AXI_RVALID && !S_AXI_RDATA[`SWKCF_RXSEL_BIT])
      else $error("receiver select visible while locked");
   a_cal_read: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY
      && S_AXI_ARADDR == ADDR_W'({`SWKCF_IDX_CAL, 2'h0})
      |=> S_AXI_RDATA == {16'h0000, $past(cal_r)})
      else $error("calibration read wrong");
   a_fd_reserved: assert property (
      S_AXI_RVALID && $rose(S_AXI_RVALID) |-> S_AXI_RDATA[31:16] == 16'h0)
      else $error("reserved upper bits not zero");
endmodule

// ### rtl/swkcf_regs.svh
// register map, field positions, reset values and timing of the wake config
`ifndef SWKCF_REGS_SVH
`define SWKCF_REGS_SVH
// register indices; byte address is four times the index
`define SWKCF_IDX_FD      8'h3b
`define SWKCF_IDX_TRIM    8'h3c
`define SWKCF_IDX_CAL     8'h3d
`define SWKCF_IDX_UNLOCK  8'h40
`define SWKCF_IDX_ERRCNT  8'h41
// fd tolerance control fields
`define SWKCF_FD_EN_BIT   0
`define SWKCF_FILT_LSB    1
`define SWKCF_FILT_MSB    3
`define SWKCF_ECD_BIT     5
`define SWKCF_FD_WMASK    16'h002f
// wake oscillator trim fields
`define SWKCF_OT_LSB      0
`define SWKCF_OT_MSB      6
`define SWKCF_TC_LSB      7
`define SWKCF_TC_MSB      11
`define SWKCF_RXSEL_BIT   14
`define SWKCF_TRIM_WMASK  16'h4fff
// unlock register and its key
`define SWKCF_KEY_MSB     1
`define SWKCF_TRIM_KEY    2'h3
// reset values
`define SWKCF_FD_RST      16'h0000
`define SWKCF_TRIM_RST    16'h0000
`define SWKCF_CAL_RST     16'h0000
`define SWKCF_UNLOCK_RST  2'h0
// dominant filter timing
`define SWKCF_FILT_STEP_NS 50
`define SWKCF_FILT_LONG_NS 775
`define SWKCF_CLK_PS       4000
`endif

// ### rtl/swkcf_pkg.sv
// types shared by the wake configuration block
package swkcf_pkg;
   typedef logic [15:0] swkcf_reg_t;
   typedef enum logic
   {
      FS_RECESSIVE = 1'b0,
      FS_DOMINANT  = 1'b1
   } swkcf_filt_e;
   typedef enum logic [1:0]
   {
      AXI_OKAY   = 2'b00,
      AXI_SLVERR = 2'b10
   } swkcf_resp_e;
endpackage

// ### testbench/swkcf_can_node.sv
// behavioural can bus node that drives the wake receiver and error events
module swkcf_can_node
(
   input  wire logic i_clk,
   output logic      o_rxd,
   output logic      o_frame_err
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idles recessive; the termination pulls the line high between frames
   initial
   begin
      o_rxd = 1'b1;
      o_frame_err = 1'b0;
   end

   // dominant phase of n samples, then release to recessive
   task automatic dominant(input int n);
      @(posedge i_clk);
      o_rxd <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_rxd <= 1'b1;
   endtask

   // one frame fault seen by the wake decoder, a single-cycle event
   task automatic frame_error();
      @(posedge i_clk);
      o_frame_err <= 1'b1;
      @(posedge i_clk);
      o_frame_err <= 1'b0;
   endtask
endmodule

// ### testbench/swkcf_bench.sv
// self-checking bench for the wake fd tolerance and trim registers
`include "swkcf_regs.svh"
module swkcf_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import swkcf_pkg::*;

   localparam logic [11:0] A_FD   = 12'(`SWKCF_IDX_FD * 4);
   localparam logic [11:0] A_TRIM = 12'(`SWKCF_IDX_TRIM * 4);
   localparam logic [11:0] A_CAL  = 12'(`SWKCF_IDX_CAL * 4);
   localparam logic [11:0] A_UNL  = 12'(`SWKCF_IDX_UNLOCK * 4);
   logic        clk, rst, awv, wv, bready, arv, rready;
   logic        swk_act, sil_exp, frame_err, rxd;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [7:0]  cal_h, cal_l, ecnt;
   logic [4:0]  tc;
   logic [3:0]  wstrb;
   logic [6:0]  ot;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        fd_en, ecnt_run, rx_std, rxd_filt;
   swkcf_resp_e bresp, rresp;
   int          num_errors, tests_run, dom_cnt, d0;
   int          ftab[8] = '{13, 25, 38, 50, 63, 75, 88, 194};

   swkcf_top DUT
   (
      .I_CLK_SYS(clk), .I_RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .I_SWK_ACTIVE(swk_act),
      .I_SILENCE_EXPIRED(sil_exp), .I_FRAME_ERR(frame_err),
      .I_CAN_RXD(rxd), .I_CAL_HIGH(cal_h), .I_CAL_LOW(cal_l),
      .O_FD_TOLERANT_EN(fd_en), .O_ERR_CNT_RUN(ecnt_run), .O_ERR_CNT(ecnt),
      .O_WAKE_RX_STD(rx_std), .O_TEMP_COEF_TRIM(tc),
      .O_OSC_COARSE_TRIM(ot), .O_RXD_FILT(rxd_filt)
   );

   swkcf_can_node node (.i_clk(clk), .o_rxd(rxd), .o_frame_err(frame_err));

   // 250 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // counts cycles in which the filtered receiver reports dominant
   always @(posedge clk)
   begin
      if (rxd_filt === 1'b0)
         dom_cnt <= dom_cnt + 1;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic timeout();
      num_errors++;
      $display("Error bus answer expected within 100 cycles seen none");
      conclude();
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_resp(input string nm, input swkcf_resp_e e,
                           input swkcf_resp_e g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // write: address and data offered together, each released when taken
   task automatic axw(input logic [11:0] a, input logic [31:0] d,
                      input swkcf_resp_e er);
      int   n;
      logic bd;
      @(posedge clk);
      n = 0;
      bd = 1'b0;
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (!bd && n < 100)
      begin
         @(posedge clk);
         n++;
         if (awv && awready)
            awv <= 1'b0;
         if (wv && wready)
            wv <= 1'b0;
         if (bvalid)
         begin
            bd = 1'b1;
            bready <= 1'b0;
            chk_resp("bresp", er, bresp);
         end
      end
      if (!bd)
         timeout();
   endtask

   // read with expected data and response
   task automatic axr(input logic [11:0] a, input logic [31:0] ed,
                      input swkcf_resp_e er);
      int   n;
      logic rd;
      @(posedge clk);
      n = 0;
      rd = 1'b0;
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      while (!rd && n < 100)
      begin
         @(posedge clk);
         n++;
         if (arv && arready)
            arv <= 1'b0;
         if (rvalid)
         begin
            rd = 1'b1;
            rready <= 1'b0;
            chk("rdata", ed, rdata);
            chk_resp("rresp", er, rresp);
         end
      end
      if (!rd)
         timeout();
   endtask

   // main sequence; wake is active except for one short drop, so the error counter may run
   initial
   begin
      {awv, wv, bready, arv, rready, sil_exp} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'h3;
      {swk_act, rst, cal_h, cal_l} = {1'b1, 1'b1, 8'ha5, 8'h3c};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      axr(A_FD, 32'h0, AXI_OKAY);
      axr(A_TRIM, 32'h0, AXI_OKAY);
      chk("receiver std", 1'b0, rx_std);
      axr(A_CAL, 32'ha53c, AXI_OKAY);
      axw(A_CAL, 32'h0, AXI_OKAY);
      cal_h <= 8'h5a;
      axr(A_CAL, 32'h5a3c, AXI_OKAY);
      axr(12'h200, 32'h0, AXI_SLVERR);
      axw(12'h200, 32'hffff, AXI_SLVERR);
      axr(12'(A_FD + 1), 32'h0, AXI_SLVERR);
      // upper lane only: every fd field sits in the lower byte
      wstrb <= 4'h2;
      axw(A_FD, 32'hffff_ffff, AXI_OKAY);
      axr(A_FD, 32'h0, AXI_OKAY);
      wstrb <= 4'h3;
      // stopped counter while fd tolerant and disable bit both set
      axw(A_FD, 32'hffff_ffff, AXI_OKAY);
      axr(A_FD, 32'h2f, AXI_OKAY);
      chk("fd enable", 1'b1, fd_en);
      chk("counter run", 1'b0, ecnt_run);
      node.frame_error();
      repeat (2) @(posedge clk);
      chk("error count", 8'd0, ecnt);
      sil_exp <= 1'b1;
      @(posedge clk);
      sil_exp <= 1'b0;
      axr(A_FD, 32'h0f, AXI_OKAY);
      chk("counter run", 1'b1, ecnt_run);
      node.frame_error();
      node.frame_error();
      repeat (2) @(posedge clk);
      chk("error count", 8'd2, ecnt);
      axw(A_FD, 32'h20, AXI_OKAY);
      chk("fd enable", 1'b0, fd_en);
      chk("counter run", 1'b1, ecnt_run);
      node.frame_error();
      repeat (2) @(posedge clk);
      chk("error count", 8'd3, ecnt);
      axr(12'(`SWKCF_IDX_ERRCNT * 4), 32'd3, AXI_OKAY);
      // leaving selective wake clears the count
      swk_act <= 1'b0;
      repeat (2) @(posedge clk);
      chk("error count", 8'd0, ecnt);
      swk_act <= 1'b1;
      // locked trim writes are dropped but still answered okay
      axw(A_TRIM, 32'hffff, AXI_OKAY);
      axr(A_TRIM, 32'h0, AXI_OKAY);
      axw(A_UNL, 32'h3, AXI_OKAY);
      axr(A_UNL, 32'h3, AXI_OKAY);
      axw(A_TRIM, 32'hffff, AXI_OKAY);
      axr(A_TRIM, 32'h4fff, AXI_OKAY);
      chk("receiver std", 1'b1, rx_std);
      chk("temp coef", 5'h1f, tc);
      chk("coarse trim", 7'h7f, ot);
      axw(A_TRIM, 32'h2a55, AXI_OKAY);
      chk("receiver std", 1'b0, rx_std);
      chk("coarse trim", 7'h55, ot);
      axw(A_TRIM, 32'h4a55, AXI_OKAY);
      axw(A_UNL, 32'h0, AXI_OKAY);
      axw(A_TRIM, 32'h0, AXI_OKAY);
      axr(A_TRIM, 32'h0a55, AXI_OKAY);
      chk("receiver std", 1'b1, rx_std);
      // every filter code: one sample short is ignored, exact length passes
      for (int c = 0; c < 8; c++)
      begin
         axw(A_FD, 32'(c * 2), AXI_OKAY);
         d0 = dom_cnt;
         node.dominant(ftab[c] - 1);
         repeat (3) @(posedge clk);
         chk("filter short", 32'd0, 32'(dom_cnt - d0));
         d0 = dom_cnt;
         node.dominant(ftab[c]);
         repeat (3) @(posedge clk);
         chk("filter pass", 32'd1, 32'(dom_cnt - d0));
      end
      conclude();
   end
endmodule
